//--- dv/pip_priority_props.sv
// Port checker of the priority block
module pip_priority_props
  import pip_pkg::*;
(
  input wire logic clk_sys_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire pip_src_type src_pending_in, src_enable_in,
  input wire logic peripheral_group_enable_in, irq_high_out, irq_low_out, priority_levels_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  wire logic act = |(src_pending_in & src_enable_in);
  wire logic ple = priority_levels_enable_out;
  property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_ack_req; !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out; endproperty
  a_ack_req: assert property (p_ack_req) else $error("stray ack");
  property p_dat_hi; wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper data");
  property p_ple_hold; !(wb_cyc_in && wb_we_in) |=> $stable(ple); endproperty
  a_ple_hold: assert property (p_ple_hold) else $error("enable moved");
  property p_ple_rst; $fell(sys_rst_in) |-> !ple; endproperty
  a_ple_rst: assert property (p_ple_rst) else $error("enable reset");
  property p_one_hi; !ple |=> irq_high_out == $past(peripheral_group_enable_in && act); endproperty
  a_one_hi: assert property (p_one_hi) else $error("single high");
  property p_one_lo; !ple |=> !irq_low_out; endproperty
  a_one_lo: assert property (p_one_lo) else $error("single low");
  property p_idle; ple && !act |=> !irq_high_out && !irq_low_out; endproperty
  a_idle: assert property (p_idle) else $error("idle request");
  c_wr: cover property (wb_ack_out && wb_we_in);
  c_lo: cover property (ple && irq_low_out);
  c_hi: cover property (!ple && irq_high_out);
endmodule
bind pip_priority pip_priority_props u_props (.clk_sys_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
  .wb_ack_out, .wb_dat_out, .src_pending_in, .src_enable_in, .peripheral_group_enable_in, .irq_high_out,
  .irq_low_out, .priority_levels_enable_out);

//--- dv/pip_src_model.sv
// Peripheral sources: sticky pending flags, cleared by the core
module pip_src_model
  import pip_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire pip_src_type raise_in,
  input wire pip_src_type clear_in,
  output pip_src_type pending_out
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_in) begin
    if (rst_in) pending_out <= '0;
    else pending_out <= (pending_out | raise_in) & ~clear_in;
  end
endmodule

//--- dv/test_pip_priority.sv
// Self-checking bench of the priority block
module test_pip_priority;
  import pip_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, gen = 1'b0, ack, hi, lo, ple, irq;
  logic [7:0] adr = '0;
  logic [6:0] ev = '0;
  logic [31:0] wd = '0, rdat, seed = 32'h0000_d566;
  pip_src_type up = '0, dn = '0, en = '0, pend;
  pip_byte_type q[$];
  pip_byte_type rv[10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h77, 8'hf7, 8'h3c, 8'h00, 8'h00, 8'h00};
  int bad_count = 0, total_checks = 0;
  pip_src_model u_pip_src_model (.clk_in(clk), .rst_in(rst), .raise_in(up), .clear_in(dn), .pending_out(pend));
  pip_priority u_pip_priority (.clk_sys_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wd), .wb_dat_out(rdat), .wb_ack_out(ack),
    .src_pending_in(pend), .src_enable_in(en), .peripheral_group_enable_in(gen),
    .config_mismatch_event_in(ev[6]), .reset_instruction_event_in(ev[5]), .watchdog_expiry_event_in(ev[4]),
    .power_down_event_in(ev[3]), .wake_event_in(ev[2]), .power_on_event_in(ev[1]), .brownout_event_in(ev[0]),
    .irq_high_out(hi), .irq_low_out(lo), .priority_levels_enable_out(ple), .irq_out(irq));
  initial forever #4 clk = ~clk;
  task automatic print_verdict;
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One classic cycle, held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input int a, input pip_byte_type d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= 8'(a);
    wd <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      print_verdict;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input int a, input pip_byte_type e);
    q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  always @(posedge clk) if (ack === 1'b1 && !we) chk(rdat, {24'h00_0000, q.pop_front()});
  initial begin
    int i, b;
    logic p;
    pip_byte_type sb;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 10; k++) rd(k * 4, rv[k]);
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, k * 4, 8'h00);
      rd(k * 4, 8'h00);
      bus(1'b1, k * 4, 8'hff);
      rd(k * 4, rv[k]);
    end
    bus(1'b1, 36, 8'hff);
    rd(36, 8'h00);
    bus(1'b1, 24, 8'hff);
    rd(24, 8'hbf);
    bus(1'b1, 24, 8'hb0);
    rd(24, 8'hbc);
    chk(ple, 1'b1);
    ev <= 7'h58;
    @(posedge clk);
    ev <= 7'h00;
    @(posedge clk);
    rd(24, 8'h90);
    chk(irq, 1'b0);
    bus(1'b1, 24, 8'hb0);
    rd(24, 8'hb0);
    ev <= 7'h27;
    @(posedge clk);
    ev <= 7'h00;
    @(posedge clk);
    rd(24, 8'ha4);
    bus(1'b1, 32, 8'h04);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rd(28, 8'h04);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    en <= '1;
    sb = 8'h00;
    for (int t = 0; t < 8; t++) begin
      seed = xs(seed);
      i = seed[7:0] % 6;
      b = seed[10:8];
      if (!rv[i][b]) b = b ^ 1;
      p = seed[16 + b];
      bus(1'b1, i * 4, seed[23:16]);
      up <= pip_src_type'(1) << (i * 8 + b);
      @(posedge clk);
      up <= '0;
      repeat (2) @(posedge clk);
      chk(hi, p);
      chk(lo, !p);
      sb = sb | (p ? 8'h01 : 8'h02);
      dn <= '1;
      @(posedge clk);
      dn <= '0;
      @(posedge clk);
    end
    rd(28, sb);
    bus(1'b1, 0, 8'h00);
    bus(1'b1, 24, 8'h20);
    up <= pip_src_type'(1);
    @(posedge clk);
    up <= '0;
    for (int g = 0; g < 2; g++) begin
      gen <= g[0];
      repeat (3) @(posedge clk);
      chk(hi, g[0]);
      chk(lo, 1'b0);
    end
    print_verdict;
  end
endmodule

//--- hw/pip_priority.sv
// Peripheral interrupt priority selection with reset cause register on Wishbone
// Operation
// RL1 - Six 8-bit priority registers hold one priority bit per peripheral source.
// RL2 - A priority bit of 1 sends its source to the high level, 0 to the low level.
// RL3 - Priority bits act only while the priority-levels enable in bit 7 of reset control is set.
// RL4 - The enable bit gives two levels when set and one compatible level when clear, and resets to 0.
// RL5 - Every implemented priority bit is read/write and resets to 1.
// RL6 - Bits 7 and 3 of the fifth, bit 3 of the sixth and bit 6 of reset control read 0 and ignore writes.
// RL7 - The mismatch flag reads 1, is cleared by a mismatch reset, and software sets it again.
// RL8 - Reset control reports reset cause: watchdog and power-down read-only at 1, reset instruction 1, others 0.
// RL9 - With priority levels off, software sets the peripheral group enable before any request is taken.
// RL10 - Pending enabled sources combined with priority drive separate high and low requests.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`include "pip_defines.svh"
module pip_priority (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire pip_pkg::pip_src_type src_pending_in,
  input wire pip_pkg::pip_src_type src_enable_in,
  input wire logic peripheral_group_enable_in,
  input wire logic config_mismatch_event_in,
  input wire logic reset_instruction_event_in,
  input wire logic watchdog_expiry_event_in,
  input wire logic power_down_event_in,
  input wire logic wake_event_in,
  input wire logic power_on_event_in,
  input wire logic brownout_event_in,
  output logic irq_high_out,
  output logic irq_low_out,
  output logic priority_levels_enable_out,
  output logic irq_out
);
  import pip_pkg::*;

  localparam pip_byte_type RCC_RST = `PIP_RCC_RESET;

  pip_byte_type prio_reg [`PIP_PRIO_COUNT];
  pip_byte_type rcc_reg;
  logic ple_reg;
  logic cmf_reg;
  logic rif_reg;
  logic wdf_reg;
  logic pdf_reg;
  logic porf_reg;
  logic bof_reg;
  logic rcc_wr;
  logic mask_wr;
  logic status_rd;
  pip_byte_type irq_status_reg;
  pip_byte_type irq_mask_reg;
  pip_bus_state_type bus_state_reg;
  logic high_req_next;
  logic low_req_next;
  logic hit;
  logic wr_en;
  logic rd_en;
  logic [2:0] word_idx;
  logic prio_sel;
  pip_byte_type wdata;
  pip_byte_type rdata_next;
  pip_byte_type irq_set;
  pip_src_type active;
  pip_src_type prio_flat;
  logic cmr_event_reg;
  logic high_prev_reg;
  logic low_prev_reg;

  function automatic pip_byte_type impl_mask(input logic [2:0] idx);
    case (idx)
      3'd4: impl_mask = `PIP_PRIO5_IMPL; // [RL6]
      3'd5: impl_mask = `PIP_PRIO6_IMPL; // [RL6]
      default: impl_mask = `PIP_PRIO_FULL;
    endcase
  endfunction

  // Bus decode, single-cycle ack on the cycle after the request
  assign hit = wb_cyc_in && wb_stb_in && (bus_state_reg == PIP_BUS_IDLE);
  assign wr_en = hit && wb_we_in && wb_sel_in[0];
  assign rd_en = hit && !wb_we_in;
  assign wdata = wb_dat_in[7:0];
  assign word_idx = wb_adr_in[4:2];
  assign prio_sel = (wb_adr_in[7:5] == 3'd0) && (wb_adr_in[4:2] < 3'd6) && (wb_adr_in[1:0] == 2'd0);
  assign rcc_wr = wr_en && (wb_adr_in == `PIP_OFS_RCC);
  assign mask_wr = wr_en && (wb_adr_in == `PIP_OFS_IRQ_MASK);
  assign status_rd = rd_en && (wb_adr_in == `PIP_OFS_IRQ_STATUS);

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      bus_state_reg <= PIP_BUS_IDLE;
    end else begin
      case (bus_state_reg)
        PIP_BUS_IDLE: begin
          if (wb_cyc_in && wb_stb_in) begin
            bus_state_reg <= PIP_BUS_ACK;
          end
        end
        PIP_BUS_ACK: bus_state_reg <= PIP_BUS_IDLE;
        default: bus_state_reg <= PIP_BUS_IDLE;
      endcase
    end
  end

  assign wb_ack_out = (bus_state_reg == PIP_BUS_ACK);

  // Priority registers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < `PIP_PRIO_COUNT; i++) begin
        prio_reg[i] <= `PIP_PRIO_RESET & impl_mask(3'(i)); // [RL5] [RL6]
      end
    end else if (wr_en && prio_sel) begin
      prio_reg[word_idx] <= wdata & impl_mask(word_idx); // [RL1] [RL5] [RL6]
    end
  end

  // Priority-levels enable
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ple_reg <= RCC_RST[`PIP_BIT_PLE]; // [RL4]
    end else if (rcc_wr) begin
      ple_reg <= wdata[`PIP_BIT_PLE]; // [RL3] [RL4]
    end
  end

  // Reset cause flags; a hardware event wins over a same-cycle write
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cmf_reg <= RCC_RST[`PIP_BIT_CMF]; // [RL7]
    end else if (config_mismatch_event_in) begin
      cmf_reg <= 1'b0; // [RL7]
    end else if (rcc_wr) begin
      cmf_reg <= wdata[`PIP_BIT_CMF]; // [RL7]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rif_reg <= RCC_RST[`PIP_BIT_RIF]; // [RL8]
    end else if (reset_instruction_event_in) begin
      rif_reg <= 1'b0; // [RL8]
    end else if (rcc_wr) begin
      rif_reg <= wdata[`PIP_BIT_RIF]; // [RL8]
    end
  end

  // Read-only for software
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wdf_reg <= RCC_RST[`PIP_BIT_WDF]; // [RL8]
    end else if (watchdog_expiry_event_in) begin
      wdf_reg <= 1'b0; // [RL8]
    end
  end

  // Read-only; power-down beats a same-cycle wake
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pdf_reg <= RCC_RST[`PIP_BIT_PDF]; // [RL8]
    end else if (power_down_event_in) begin
      pdf_reg <= 1'b0; // [RL8]
    end else if (wake_event_in) begin
      pdf_reg <= 1'b1; // [RL8]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      porf_reg <= RCC_RST[`PIP_BIT_PORF]; // [RL8]
    end else if (power_on_event_in) begin
      porf_reg <= 1'b0; // [RL8]
    end else if (rcc_wr) begin
      porf_reg <= wdata[`PIP_BIT_PORF]; // [RL8]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      bof_reg <= RCC_RST[`PIP_BIT_BOF]; // [RL8]
    end else if (brownout_event_in) begin
      bof_reg <= 1'b0; // [RL8]
    end else if (rcc_wr) begin
      bof_reg <= wdata[`PIP_BIT_BOF]; // [RL8]
    end
  end

  // Bit 6 has no flop and reads 0
  assign rcc_reg = {ple_reg, 1'b0, cmf_reg, rif_reg, wdf_reg, pdf_reg, porf_reg, bof_reg}; // [RL6] [RL8]

  assign priority_levels_enable_out = rcc_reg[`PIP_BIT_PLE]; // [RL4]

  // Request routing toward the core
  always_comb begin
    for (int r = 0; r < `PIP_PRIO_COUNT; r++) begin
      prio_flat[r*8 +: 8] = prio_reg[r];
    end
    active = src_pending_in & src_enable_in; // [RL10]
    if (rcc_reg[`PIP_BIT_PLE]) begin
      high_req_next = |(active & prio_flat); // [RL2] [RL3]
      low_req_next = |(active & ~prio_flat); // [RL2]
    end else begin
      high_req_next = peripheral_group_enable_in && |active; // [RL4] [RL9]
      low_req_next = 1'b0; // [RL3]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      irq_high_out <= 1'b0;
    end else begin
      irq_high_out <= high_req_next; // [RL10]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      irq_low_out <= 1'b0;
    end else begin
      irq_low_out <= low_req_next; // [RL10]
    end
  end

  // Event capture for the status register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      high_prev_reg <= 1'b0;
    end else begin
      high_prev_reg <= irq_high_out;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      low_prev_reg <= 1'b0;
    end else begin
      low_prev_reg <= irq_low_out;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cmr_event_reg <= 1'b0;
    end else begin
      cmr_event_reg <= config_mismatch_event_in;
    end
  end

  always_comb begin
    irq_set = `PIP_IRQ_RESET;
    irq_set[`PIP_IRQ_HI] = irq_high_out && !high_prev_reg;
    irq_set[`PIP_IRQ_LO] = irq_low_out && !low_prev_reg;
    irq_set[`PIP_IRQ_CMR] = cmr_event_reg;
  end

  // Sticky status cleared by read; a new event wins over the clear
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      irq_status_reg <= `PIP_IRQ_RESET;
    end else if (status_rd) begin
      irq_status_reg <= irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      irq_mask_reg <= `PIP_IRQ_RESET;
    end else if (mask_wr) begin
      irq_mask_reg <= wdata & 8'h07;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Read data, registered with the ack
  always_comb begin
    rdata_next = 8'h00;
    if (prio_sel) begin
      rdata_next = prio_reg[word_idx]; // [RL6]
    end else begin
      case (wb_adr_in)
        `PIP_OFS_RCC: rdata_next = rcc_reg & 8'hBF; // [RL6]
        `PIP_OFS_IRQ_STATUS: rdata_next = irq_status_reg;
        `PIP_OFS_IRQ_MASK: rdata_next = irq_mask_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (rd_en) begin
      wb_dat_out <= {24'h00_0000, rdata_next};
    end
  end
endmodule

//--- pkg/pip_defines.svh
// Register offsets, field positions, reset values and masks of the priority block
`ifndef PIP_DEFINES_SVH
`define PIP_DEFINES_SVH
`define PIP_OFS_PRIO1 8'h00
`define PIP_OFS_PRIO2 8'h04
`define PIP_OFS_PRIO3 8'h08
`define PIP_OFS_PRIO4 8'h0C
`define PIP_OFS_PRIO5 8'h10
`define PIP_OFS_PRIO6 8'h14
`define PIP_OFS_RCC 8'h18
`define PIP_OFS_IRQ_STATUS 8'h1C
`define PIP_OFS_IRQ_MASK 8'h20
`define PIP_PRIO_COUNT 6
`define PIP_PRIO_RESET 8'hFF
`define PIP_PRIO5_IMPL 8'h77
`define PIP_PRIO6_IMPL 8'hF7
`define PIP_PRIO_FULL 8'hFF
`define PIP_RCC_RESET 8'h3C
`define PIP_RCC_WMASK 8'hB3
`define PIP_BIT_PLE 7
`define PIP_BIT_CMF 5
`define PIP_BIT_RIF 4
`define PIP_BIT_WDF 3
`define PIP_BIT_PDF 2
`define PIP_BIT_PORF 1
`define PIP_BIT_BOF 0
`define PIP_IRQ_HI 0
`define PIP_IRQ_LO 1
`define PIP_IRQ_CMR 2
`define PIP_IRQ_RESET 8'h00
`endif

//--- pkg/pip_pkg.sv
// Types shared by the peripheral priority block
package pip_pkg;
  typedef logic [7:0] pip_byte_type;
  typedef logic [47:0] pip_src_type;
  typedef enum logic [1:0] {
    PIP_BUS_IDLE = 2'b01,
    PIP_BUS_ACK = 2'b10
  } pip_bus_state_type;
endpackage
